// *** hdl/sst_pkg.sv ***
/*
 * Package for the synchronous serial transmit buffer and status block.
 * Holds status bit positions, word-length codes, sizes and the control
 * carrier type. Assumes the control register decode outside this block
 * delivers the control bits as plain levels and pulses on REF_CLK.
 */
package sst_pkg;

    // ***************************************************************
    // Sizes
    // ***************************************************************
    localparam int DATA_W = 8;             // Stage width
    localparam int DEPTH  = 3;             // Stages per FIFO
    localparam int CNT_W  = 4;             // Bit counter width

    // ***************************************************************
    // Status word bit positions
    // ***************************************************************
    localparam int ST_RDA  = 0;            // Receive data available
    localparam int ST_TX_ROOM_FLAG = 1;            // Transmit room
    localparam int ST_DCD  = 2;            // Carrier detect
    localparam int ST_CTS  = 3;            // Clear to send
    localparam int ST_TUF  = 4;            // Transmit underflow
    localparam int ST_OVRN = 5;            // Receive overrun
    localparam int ST_PE   = 6;            // Parity error
    localparam int ST_IRQ  = 7;            // Interrupt summary

    // ***************************************************************
    // Reset values and word-length codes
    // ***************************************************************
    localparam logic [7:0] STATUS_RST = 8'h00;    // Status after reset
    localparam logic [7:0] FILL_ONES  = 8'hff;    // All-ones fill
    localparam logic [2:0] WS_7_NOPAR = 3'h2;     // 7 bits, no parity
    localparam logic [2:0] WS_8_NOPAR = 3'h3;     // 8 bits, no parity
    localparam logic [CNT_W-1:0] LEN_6 = 4'h6;    // Six data bits
    localparam logic [CNT_W-1:0] LEN_7 = 4'h7;    // Seven data bits
    localparam logic [CNT_W-1:0] LEN_8 = 4'h8;    // Eight data bits

    // ***************************************************************
    // Control bits delivered by the register decode
    // ***************************************************************
    typedef struct packed {
        logic       rx_interrupt_enable;    // Enable on data available
        logic       tx_interrupt_enable;    // Enable on room
        logic       error_interrupt_enable; // Enable on bits 6..2
        logic       tx_section_reset;       // Level, holds transmitter
        logic       rx_section_reset;       // Level, holds receiver
        logic       clear_underflow_cmd;    // One-cycle pulse
        logic       clear_cts_cmd;          // One-cycle pulse
        logic       one_sync;               // One-sync versus two-sync
        logic       ext_sync;               // External sync mode
        logic       tx_sync_fill;           // Sync fill on underflow
        logic [2:0] word_sel;               // Word length select
        logic       one_byte;               // 1-byte transfer mode
        logic [7:0] sync_code;              // Sync-code register
    } sst_ctrl_t;

endpackage : sst_pkg

// *** hdl/sst_tx_status.sv ***
/*
 * Transmit FIFO, receive FIFO flags, transmitter and status word of a
 * synchronous serial adapter. REF_CLK is the bus phase clock; CE is the
 * phase pulse. Assumes host strobes are single REF_CLK pulses aligned
 * with CE, and that TX_CLK, DCD and CTS are asynchronous pins.
 */
module sst_tx_status (
    input  wire logic              REF_CLK,     // Bus phase clock
    input  wire logic              RSTN,        // Global reset, low
    input  wire logic              CE,          // Clock enable
    input  wire sst_pkg::sst_ctrl_t CTRL,       // Control bits
    input  wire logic              TX_WR,       // Host write pulse
    input  wire logic [7:0]        TX_DATA,     // Host write data
    input  wire logic              STAT_RD,     // Status read pulse
    input  wire logic              RX_RD,       // Receive FIFO read pulse
    input  wire logic              RX_WR,       // Receiver char pulse
    input  wire logic [7:0]        RX_CHAR,     // Received character
    input  wire logic              RX_PERR,     // Its parity mismatch
    input  wire logic              TX_CLK,      // Transmit bit clock pin
    input  wire logic              DCD,         // Carrier detect pin
    input  wire logic              CTS,         // Clear to send pin
    output logic [7:0]             STATUS,      // Status word
    output logic [7:0]             RX_Q,        // Last receive stage
    output logic                   TXD,         // Serial data out
    output logic                   TX_UF,       // Underflow pulse pin
    output logic                   IRQ_N        // Interrupt, low active
);

    // ***************************************************************
    // Pin synchronisers
    // ***************************************************************
    logic [2:0] txc_s;                     // Tx clock sync and history
    logic [2:0] dcd_s;                     // DCD sync and history
    logic [2:0] cts_s;                     // CTS sync and history

    // Bit 0 is only read by bit 1; bit 2 is a history copy for edges
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            txc_s <= 3'h0;
            dcd_s <= 3'h0;
            cts_s <= 3'h0;
        end else if (CE) begin
            txc_s <= {txc_s[1:0], TX_CLK};
            dcd_s <= {dcd_s[1:0], DCD};
            cts_s <= {cts_s[1:0], CTS};
        end
    end

    wire tx_rise  = txc_s[1] & ~txc_s[2];  // Bit clock rising
    wire tx_fall  = ~txc_s[1] & txc_s[2];  // Bit clock falling
    wire dcd_live = dcd_s[1];              // Synchronised DCD
    wire cts_live = cts_s[1];              // Synchronised CTS
    wire dcd_rise = dcd_s[1] & ~dcd_s[2];  // DCD positive transition
    wire cts_rise = cts_s[1] & ~cts_s[2];  // CTS positive transition

    // ***************************************************************
    // Word format decode
    // ***************************************************************
    wire [2:0] ws = CTRL.word_sel;         // Word length select
    wire par_en = (ws != sst_pkg::WS_7_NOPAR) &&
                  (ws != sst_pkg::WS_8_NOPAR);   // Parity appended
    wire [sst_pkg::CNT_W-1:0] data_len =
        (ws[2:1] == 2'b00) ? sst_pkg::LEN_6 :
        ((ws == sst_pkg::WS_7_NOPAR) || (ws[2:1] == 2'b10)) ?
        sst_pkg::LEN_7 : sst_pkg::LEN_8;   // Data bits per character
    wire [7:0] data_mask = (ws[2:1] == 2'b00) ? 8'h3f :
                           (data_len == sst_pkg::LEN_7) ? 8'h7f : 8'hff;

    // ***************************************************************
    // Transmit FIFO
    // ***************************************************************
    logic [7:0] tf_data [sst_pkg::DEPTH];  // Stage data, 0 is first
    logic [2:0] tf_full;                   // Stage full flags
    logic       txrst_q;                   // Tx reset history
    logic       tx_take;                   // Transmitter takes stage 2
    // The bit counter lives here because the boundary decode below
    // needs it; the transmitter section drives it
    logic [sst_pkg::CNT_W-1:0] bit_cnt;    // Bits left in character

    wire tx_rst_edge = CTRL.tx_section_reset & ~txrst_q; // One pulse on entry to reset
    wire tx_run = ~CTRL.tx_section_reset;  // Transmitter not held
    wire boundary = tx_run & tx_fall & (bit_cnt == '0); // Char boundary

    // Ripple rule: stage i moves on when stage i+1 is empty
    // Bit i of the move vector means a character enters stage i, so
    // bit 0 is always zero: only a host write fills the first stage
    // A character advances at most one stage per enabled cycle
    wire [2:0] tf_move = {tf_full[1] & ~tf_full[2],
                          tf_full[0] & ~tf_full[1], 1'b0};
    // Writes land only in an empty first stage; CTS is not consulted
    wire tf_load = TX_WR & ~tf_full[0];

    // Clear once on entering reset, then accept preload writes
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tf_full <= 3'h0;
            txrst_q <= 1'b0;
        end else if (CE) begin
            txrst_q <= CTRL.tx_section_reset;
            if (tx_rst_edge) begin
                tf_full <= 3'h0;
            end else begin
                tf_full[0] <= tf_load | (tf_full[0] & ~tf_move[1]);
                tf_full[1] <= tf_move[1] | (tf_full[1] & ~tf_move[2]);
                tf_full[2] <= tf_move[2] | (tf_full[2] & ~tx_take);
            end
        end
    end

    // Data path; stale data in empty stages is never used
    always_ff @(posedge REF_CLK) begin
        if (CE) begin
            if (tf_load) begin
                tf_data[0] <= TX_DATA & data_mask;
            end
            if (tf_move[1]) begin
                tf_data[1] <= tf_data[0];
            end
            if (tf_move[2]) begin
                tf_data[2] <= tf_data[1];
            end
        end
    end

    // ***************************************************************
    // Transmitter
    // ***************************************************************
    // Bit counter is declared with the FIFO, ahead of its first use
    logic [8:0]                tx_sh;      // Remaining frame bits
    logic                      uf_pend;    // Sync fill pulse pending

    wire under = ~tf_full[2];              // Nothing ready at boundary
    wire [7:0] fill_char = CTRL.tx_sync_fill ? CTRL.sync_code
                                             : sst_pkg::FILL_ONES;
    wire [7:0] char_raw = under ? fill_char : tf_data[2];
    wire [7:0] char_m   = char_raw & data_mask;
    wire       char_par = ^char_m ^ ws[0]; // Even or odd parity
    wire [8:0] frame = par_en ?
        (9'({1'b0, char_m}) | (9'(char_par) << data_len)) :
        {1'b0, char_m};
    wire [sst_pkg::CNT_W-1:0] frame_len = data_len +
        (par_en ? 4'h1 : 4'h0);            // Bits per character

    assign tx_take = boundary & tf_full[2];

    // Shift out LSB first, changing data on the falling bit clock edge
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            bit_cnt <= '0;
            tx_sh   <= 9'h1ff;
            TXD     <= 1'b1;
        end else if (CE) begin
            if (!tx_run) begin
                bit_cnt <= '0;              // Idle mark while held
                TXD     <= 1'b1;
            end else if (boundary) begin
                TXD     <= frame[0];
                tx_sh   <= frame >> 1;
                bit_cnt <= frame_len - 4'h1;
            end else if (tx_fall) begin
                TXD     <= tx_sh[0];
                tx_sh   <= tx_sh >> 1;
                bit_cnt <= bit_cnt - 4'h1;
            end
        end
    end

    // Pulse spans the next high period of the bit clock
    // The event is seen at a falling edge, so the pulse is held back
    // until the following rise; a bit clock that stops low leaves it
    // pending, which is harmless as no pulse can then be due
    // Ones fill never raises the pin, only sync-code fill does
    wire uf_event = boundary & under & CTRL.tx_sync_fill;

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            uf_pend <= 1'b0;
            TX_UF   <= 1'b0;
        end else if (CE) begin
            if (uf_event) begin
                uf_pend <= 1'b1;
            end else if (tx_rise && uf_pend) begin
                uf_pend <= 1'b0;
            end
            if (tx_rise && uf_pend) begin
                TX_UF <= 1'b1;
            end else if (tx_fall || !tx_run) begin
                TX_UF <= 1'b0;
            end
        end
    end

    // ***************************************************************
    // Receive FIFO flags
    // ***************************************************************
    logic [7:0] rf_data [sst_pkg::DEPTH];  // Receive stage data
    logic [2:0] rf_full;                   // Receive stage full flags
    logic [2:0] rf_perr;                   // Parity mismatch per stage

    wire rx_hold = CTRL.rx_section_reset;  // Receiver held in reset
    wire rf_pop  = RX_RD & rf_full[2];     // Host takes last stage
    wire [2:0] rf_move = {rf_full[1] & ~rf_full[2],
                          rf_full[0] & ~rf_full[1], 1'b0}; // Ripple
    wire ovrn_event = RX_WR & rf_full[0] & ~rx_hold;

    // Overrun overwrites the first stage, as the receiver would
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rf_full <= 3'h0;
        end else if (CE) begin
            if (rx_hold) begin
                rf_full <= 3'h0;
            end else begin
                rf_full[0] <= RX_WR | (rf_full[0] & ~rf_move[1]);
                rf_full[1] <= rf_move[1] | (rf_full[1] & ~rf_move[2]);
                rf_full[2] <= rf_move[2] | (rf_full[2] & ~rf_pop);
            end
        end
    end

    // Parity tag travels with its character
    always_ff @(posedge REF_CLK) begin
        if (CE) begin
            if (RX_WR) begin
                rf_data[0] <= RX_CHAR;
                rf_perr[0] <= RX_PERR;
            end
            if (rf_move[1]) begin
                rf_data[1] <= rf_data[0];
                rf_perr[1] <= rf_perr[0];
            end
            if (rf_move[2]) begin
                rf_data[2] <= rf_data[1];
                rf_perr[2] <= rf_perr[1];
            end
        end
    end

    // ***************************************************************
    // Latched flags
    // ***************************************************************
    logic stat_seen;                       // Status read since FIFO read
    logic dcd_lat;                         // Stored DCD rise
    logic dcd_follow;                      // Bit 2 shows live DCD
    logic cts_lat;                         // Stored CTS rise
    logic cts_follow;                      // Bit 3 shows live CTS
    logic tx_underflow_flag;                             // Underflow flag
    logic ovrn;                            // Overrun flag

    // Clear sequence: status read, then a receive FIFO read
    wire rd_seq  = RX_RD & stat_seen;
    wire dcd_clr = rd_seq | rx_hold;
    wire cts_clr = CTRL.clear_cts_cmd | CTRL.tx_section_reset;
    wire tuf_clr = CTRL.clear_underflow_cmd | CTRL.tx_section_reset;

    // Setting events win over clears in the same cycle
    // Limitation: a clear that lands with a new edge is lost, so the
    // host must clear again after servicing that edge
    // Status reads only arm the clear sequence; they clear nothing
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            stat_seen  <= 1'b0;
            dcd_lat    <= 1'b0;
            dcd_follow <= 1'b0;
            cts_lat    <= 1'b0;
            cts_follow <= 1'b0;
            tx_underflow_flag        <= 1'b0;
            ovrn       <= 1'b0;
        end else if (CE) begin
            if (STAT_RD) begin
                stat_seen <= 1'b1;
            end else if (RX_RD) begin
                stat_seen <= 1'b0;
            end
            if (dcd_rise) begin
                dcd_lat    <= 1'b1;
                dcd_follow <= 1'b0;
            end else if (dcd_clr) begin
                dcd_lat    <= 1'b0;
                dcd_follow <= rd_seq;
            end
            if (cts_rise) begin
                cts_lat    <= 1'b1;
                cts_follow <= 1'b0;
            end else if (cts_clr) begin
                cts_lat    <= 1'b0;
                cts_follow <= CTRL.clear_cts_cmd;
            end
            if (uf_event) begin
                tx_underflow_flag <= 1'b1;
            end else if (tuf_clr) begin
                tx_underflow_flag <= 1'b0;
            end
            if (ovrn_event) begin
                ovrn <= 1'b1;
            end else if (rd_seq || rx_hold) begin
                ovrn <= 1'b0;
            end
        end
    end

    // ***************************************************************
    // Status word and interrupt
    // ***************************************************************
    // Flags derive from stage occupancy, so they drop by themselves
    // Both flags pass one register stage, so they trail the FIFO by
    // one cycle; the host strobes are spaced to allow for that
    wire rx_data_avail_flag = CTRL.one_byte ? rf_full[2]
                             : (rf_full[2] & rf_full[1]);
    wire cts_block = cts_live & ~CTRL.ext_sync;
    wire room = CTRL.one_byte ? ~tf_full[0]
                              : ~(tf_full[0] | tf_full[1]);
    wire tx_room_flag = room & ~CTRL.tx_section_reset & ~cts_block;
    wire dcd_bit = dcd_lat | (dcd_follow & dcd_live);
    wire cts_bit = cts_lat | (cts_follow & cts_live);
    wire pe_bit  = rf_full[2] & rf_perr[2];
    wire [4:0] err_bits = {pe_bit, ovrn, tx_underflow_flag, cts_bit, dcd_bit};
    wire next_irq = (CTRL.rx_interrupt_enable & rx_data_avail_flag) |
                    (CTRL.tx_interrupt_enable & tx_room_flag) |
                    (CTRL.error_interrupt_enable & (|err_bits));
    wire [7:0] next_status = {next_irq, err_bits, tx_room_flag, rx_data_avail_flag};

    // Snapshot only; reading it clears no flag
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            STATUS <= sst_pkg::STATUS_RST;
            IRQ_N  <= 1'b1;
            RX_Q   <= 8'h00;
        end else if (CE) begin
            STATUS <= next_status;
            IRQ_N  <= ~next_irq;
            RX_Q   <= rf_data[2];
        end
    end

endmodule // sst_tx_status

// *** dv/sst_tx_status_checker.sv ***
/* Port-level assertions for sst_tx_status.
   Assumes CE is held high and the bind at the foot attaches it. */
module sst_tx_status_checker (
    input wire logic               REF_CLK,  // Clock
    input wire logic               RSTN,     // Reset, low
    input wire logic               CE,       // Enable
    input wire sst_pkg::sst_ctrl_t CTRL,     // Control
    input wire logic               TX_WR,    // Write
    input wire logic [7:0]         TX_DATA,  // Write data
    input wire logic               STAT_RD,  // Status read
    input wire logic               RX_RD,    // Rx read
    input wire logic               RX_WR,    // Rx char
    input wire logic [7:0]         RX_CHAR,  // Rx data
    input wire logic               RX_PERR,  // Rx parity
    input wire logic               TX_CLK,   // Bit clock
    input wire logic               DCD,      // Carrier
    input wire logic               CTS,      // Clear to send
    input wire logic [7:0]         STATUS,   // Status word
    input wire logic [7:0]         RX_Q,     // Rx stage 3
    input wire logic               TXD,      // Serial out
    input wire logic               TX_UF,    // Underflow pin
    input wire logic               IRQ_N     // Interrupt
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    a_irq_mirror: assert property (STATUS[7] == !IRQ_N)
        else $error("irq bit differs from pin");
    a_room_cts: assert property ((CTS && !CTRL.ext_sync) [*5] |-> !STATUS[1])
        else $error("room flag high under cts");
    a_room_txrst: assert property (CTRL.tx_section_reset [*3] |-> !STATUS[1])
        else $error("room flag high in tx reset");
    a_tuf_txrst: assert property (CTRL.tx_section_reset [*3] |-> !STATUS[4])
        else $error("underflow flag held in tx reset");
    a_dcd_set: assert property ($rose(DCD) && !CTRL.rx_section_reset
        |-> ##[1:6] STATUS[2])
        else $error("carrier edge not latched");
    a_cts_set: assert property ($rose(CTS) && !CTRL.tx_section_reset
        |-> ##[1:6] STATUS[3])
        else $error("cts edge not latched");
    a_uf_ones: assert property (!CTRL.tx_sync_fill [*8] |-> !TX_UF)
        else $error("underflow pulse during ones fill");
    a_rx_rst_flags: assert property (CTRL.rx_section_reset [*3]
        |-> STATUS[6:5] == 2'h0 && !STATUS[0])
        else $error("rx flags survive rx reset");
    a_irq_off: assert property (!(CTRL.rx_interrupt_enable
        || CTRL.tx_interrupt_enable || CTRL.error_interrupt_enable) [*3]
        |-> IRQ_N)
        else $error("interrupt with all enables off");
endmodule // sst_tx_status_checker

bind sst_tx_status sst_tx_status_checker i_chk (.REF_CLK(REF_CLK),
    .RSTN(RSTN), .CE(CE), .CTRL(CTRL), .TX_WR(TX_WR), .TX_DATA(TX_DATA),
    .STAT_RD(STAT_RD), .RX_RD(RX_RD), .RX_WR(RX_WR), .RX_CHAR(RX_CHAR),
    .RX_PERR(RX_PERR), .TX_CLK(TX_CLK), .DCD(DCD), .CTS(CTS),
    .STATUS(STATUS), .RX_Q(RX_Q), .TXD(TXD), .TX_UF(TX_UF), .IRQ_N(IRQ_N));

// *** dv/sst_line_model.sv ***
/* Modem side: makes the 200 ns bit clock and collects sent bits.
   Assumes the block changes its data a few cycles after a falling edge. */
module sst_line_model (
    input  wire logic  run,    // Let the bit clock run
    input  wire logic  txd,    // Serial data from the block
    output logic       tx_clk, // Transmit bit clock
    output logic [7:0] last8   // Last eight bits, oldest at bit 0
);
    timeunit 1ns;
    timeprecision 100ps;
    // Clock parks low between bursts; odd offset keeps it off the bus clock
    initial begin
        tx_clk = 1'b0;
        #37;
        forever begin
            #100;
            if (run || tx_clk) tx_clk = ~tx_clk;
        end
    end
    // Sample just before the block moves on, least significant first
    initial last8 = 8'h00;
    always @(negedge tx_clk) last8 <= {txd, last8[7:1]};
endmodule // sst_line_model

// *** dv/sst_tx_status_tb.sv ***
/* Self-checking bench for sst_tx_status and its line model.
   Assumes a 40 MHz bus clock and strobes one cycle wide. */
module sst_tx_status_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, rstn, tx_wr, stat_rd, rx_rd, rx_wr, rx_perr;
    logic dcd, cts, run, txd, tx_uf, irq_n, tx_clk, uf_seen;
    logic [7:0] tx_data, rx_char, status, rx_q, last8;
    sst_pkg::sst_ctrl_t ctrl;  // Control bits
    int error_cnt, check_count;
    sst_tx_status i_dut (.REF_CLK(ref_clk), .RSTN(rstn), .CE(1'b1),
        .CTRL(ctrl), .TX_WR(tx_wr), .TX_DATA(tx_data), .STAT_RD(stat_rd),
        .RX_RD(rx_rd), .RX_WR(rx_wr), .RX_CHAR(rx_char), .RX_PERR(rx_perr),
        .TX_CLK(tx_clk), .DCD(dcd), .CTS(cts), .STATUS(status), .RX_Q(rx_q),
        .TXD(txd), .TX_UF(tx_uf), .IRQ_N(irq_n));
    sst_line_model i_line (.run(run), .txd(txd), .tx_clk(tx_clk),
        .last8(last8));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic sb(input int pos, input logic exp);
        chk({7'h0, status[pos]}, {7'h0, exp});
    endtask
    // Settle away from the sampling edge
    task automatic go(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge ref_clk); tx_wr <= 1'b1; tx_data <= d;
        @(posedge ref_clk); tx_wr <= 1'b0;
    endtask
    task automatic rx_put(input logic [7:0] d, input logic p);
        @(posedge ref_clk); rx_wr <= 1'b1; rx_char <= d; rx_perr <= p;
        @(posedge ref_clk); rx_wr <= 1'b0;
    endtask
    task automatic rd_pair;
        @(posedge ref_clk); stat_rd <= 1'b1;
        @(posedge ref_clk); stat_rd <= 1'b0; rx_rd <= 1'b1;
        @(posedge ref_clk); rx_rd <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ****************************************
    // Clock, watchdog, pulse catcher
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        #200us;
        error_cnt++;
        wrap_up;
    end
    always @(posedge ref_clk) if (tx_uf) uf_seen <= 1'b1;
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {rstn, tx_wr, stat_rd, rx_rd, rx_wr, rx_perr, dcd, cts} = 8'h00;
        {run, uf_seen, tx_data, rx_char, error_cnt, check_count} = '0;
        ctrl = '0;
        ctrl.one_byte = 1'b1;
        ctrl.word_sel = sst_pkg::WS_8_NOPAR;
        ctrl.sync_code = 8'h5a;
        go(10);
        chk(status, sst_pkg::STATUS_RST);
        rstn <= 1'b1;
        go(4);
        sb(sst_pkg::ST_TX_ROOM_FLAG, 1'b1);
        wr(8'ha1);
        wr(8'ha2);
        go(4);
        sb(sst_pkg::ST_TX_ROOM_FLAG, 1'b1);
        ctrl.one_byte <= 1'b0;
        go(3);
        sb(sst_pkg::ST_TX_ROOM_FLAG, 1'b0);
        ctrl.one_byte <= 1'b1;
        wr(8'ha3);
        go(3);
        sb(sst_pkg::ST_TX_ROOM_FLAG, 1'b0);
        run <= 1'b1;
        go(300);
        sb(sst_pkg::ST_TX_ROOM_FLAG, 1'b1);
        chk(last8, sst_pkg::FILL_ONES);
        sb(sst_pkg::ST_TUF, 1'b0);
        ctrl.tx_sync_fill <= 1'b1;
        go(80);
        sb(sst_pkg::ST_TUF, 1'b1);
        chk({7'h0, uf_seen}, 8'h01);
        run <= 1'b0;
        go(20);
        ctrl.clear_underflow_cmd <= 1'b1;
        go(0);
        ctrl.clear_underflow_cmd <= 1'b0;
        ctrl.tx_sync_fill <= 1'b0;
        go(4);
        sb(sst_pkg::ST_TUF, 1'b0);
        $display("transmit tests done");
        ctrl.error_interrupt_enable <= 1'b1;
        cts <= 1'b1;
        go(6);
        sb(sst_pkg::ST_CTS, 1'b1);
        sb(sst_pkg::ST_TX_ROOM_FLAG, 1'b0);
        chk({7'h0, irq_n}, 8'h00);
        ctrl.ext_sync <= 1'b1;
        go(4);
        sb(sst_pkg::ST_TX_ROOM_FLAG, 1'b1);
        ctrl.ext_sync <= 1'b0;
        ctrl.clear_cts_cmd <= 1'b1;
        go(0);
        ctrl.clear_cts_cmd <= 1'b0;
        go(4);
        sb(sst_pkg::ST_CTS, 1'b1);
        cts <= 1'b0;
        go(5);
        sb(sst_pkg::ST_CTS, 1'b0);
        chk({7'h0, irq_n}, 8'h01);
        ctrl.tx_section_reset <= 1'b1;
        go(3);
        wr(8'hb1);
        wr(8'hb2);
        wr(8'hb3);
        go(4);
        sb(sst_pkg::ST_TX_ROOM_FLAG, 1'b0);
        ctrl.tx_section_reset <= 1'b0;
        go(4);
        sb(sst_pkg::ST_TX_ROOM_FLAG, 1'b0);
        $display("cts and preload tests done");
        rx_put(8'h3c, 1'b1);
        dcd <= 1'b1;
        go(6);
        dcd <= 1'b0;
        go(6);
        sb(sst_pkg::ST_DCD, 1'b1);
        chk(status[6:0] & 8'h41, 8'h41);
        chk(rx_q, 8'h3c);
        ctrl.one_byte <= 1'b0;
        go(3);
        sb(sst_pkg::ST_RDA, 1'b0);
        ctrl.one_byte <= 1'b1;
        rd_pair;
        go(4);
        chk(status[6:0] & 8'h45, 8'h00);
        repeat (4) rx_put(8'h11, 1'b0);
        go(4);
        sb(sst_pkg::ST_OVRN, 1'b1);
        rd_pair;
        go(4);
        sb(sst_pkg::ST_OVRN, 1'b0);
        ctrl.rx_section_reset <= 1'b1;
        go(4);
        sb(sst_pkg::ST_RDA, 1'b0);
        $display("receive flag tests done");
        wrap_up;
    end
endmodule // sst_tx_status_tb
